// ==== cpc_pkg.sv ====
// Constants, register map and carrier types of the clock and power control.
// Assumes one 20 MHz bus clock; oscillators arrive as sampled levels.
package cpc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned HCLK_MHZ       = 20;
  localparam int unsigned RC_OSC_MHZ     = 12;
  localparam int unsigned PLL_SETTLE_US  = 100;
  localparam int unsigned PLL_SETTLE_CYC = PLL_SETTLE_US * HCLK_MHZ;
  localparam int unsigned PLL_CNT_W      = $clog2(PLL_SETTLE_CYC + 1);

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_MAIN_SEL  = 8'h00;
  localparam logic [7:0] OFF_SYS_SRC   = 8'h04;
  localparam logic [7:0] OFF_PLL_IN    = 8'h08;
  localparam logic [7:0] OFF_PLL_CTRL  = 8'h0c;
  localparam logic [7:0] OFF_PLL_STAT  = 8'h10;
  localparam logic [7:0] OFF_OUT_SEL   = 8'h14;
  localparam logic [7:0] OFF_WDT_SEL   = 8'h18;
  localparam logic [7:0] OFF_CPU_DIV   = 8'h1c;
  localparam logic [7:0] OFF_PCLK_EN   = 8'h20;
  localparam logic [7:0] OFF_PDIV0     = 8'h24;
  localparam logic [7:0] OFF_PDIV_STEP = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h40;

  // ----------------------------------------
  // Fields and encodings
  // ----------------------------------------
  localparam int unsigned PLL_MSEL_LSB = 0;
  localparam int unsigned PLL_MSEL_W   = 5;
  localparam int unsigned PLL_PSEL_LSB = 5;
  localparam int unsigned PLL_PSEL_W   = 2;
  localparam int unsigned PLL_EN_BIT   = 8;
  localparam int unsigned ST_SLEEP_BIT = 0;
  localparam int unsigned ST_MAIN_LSB  = 1;
  localparam int unsigned ST_LOCK_BIT  = 3;
  localparam int unsigned DIV_W        = 8;
  localparam int unsigned POST_W       = 5;

  localparam logic [1:0] SRC_RC     = 2'h0;
  localparam logic [1:0] SRC_SYS    = 2'h1;
  localparam logic [1:0] SRC_PLL    = 2'h2;
  localparam logic [1:0] SRC_LF     = 2'h3;
  localparam logic [1:0] SYS_XTAL   = 2'h0;
  localparam logic [1:0] SYS_EXTPIN = 2'h1;
  localparam logic [1:0] SYS_CRYSTAL_INPUT_PIN = 2'h2;
  localparam logic [4:0] POST_BASE  = 5'h02;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0]       RST_MAIN_SEL = SRC_RC;
  localparam logic [1:0]       RST_SYS_SRC  = SYS_XTAL;
  localparam logic [8:0]       RST_PLL_CTRL = 9'h000;
  localparam logic [DIV_W-1:0] RST_CPU_DIV  = 8'h01;
  localparam logic [DIV_W-1:0] RST_PDIV     = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {GFM_RUN, GFM_ENGAGE} cpc_gfm_phase_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } cpc_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } cpc_ahb_rsp_t;

  typedef struct packed {
    logic internal_rc_osc;
    logic crystal_osc;
    logic external_clock_input_pin;
    logic crystal_input_pin;
    logic low_freq_osc;
    logic watchdog_osc;
    logic current_controlled_osc;
  } cpc_osc_t;

  typedef struct packed {
    logic       power_down;
    logic [5:0] mult;
    logic       ref_clk;
  } cpc_pll_ctl_t;
endpackage : cpc_pkg

// ==== cpc_gf_mux.sv ====
// Glitch-free clock selector working on sampled clock levels.
// Assumes inputs are already synchronised to hclk.
`timescale 1ns/100ps
module cpc_gf_mux #(
  parameter int unsigned N = 4,
  parameter int unsigned W = 2
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Sources and selection
  input  wire logic [N-1:0] clk_in,
  input  wire logic [W-1:0] sel,
  // Result
  output logic              clk_out,
  output logic [W-1:0]      cur_sel
);
  import cpc_pkg::*;

  typedef struct packed {
    logic [W-1:0]   cur;
    cpc_gfm_phase_t phase;
    logic           out;
  } cpc_gfm_state_t;

  cpc_gfm_state_t s_reg, s_next;

  // Old source dropped only while low; new one joined only while low
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.phase)
      GFM_RUN: begin
        if (sel != s_reg.cur && 32'(sel) < N && !clk_in[s_reg.cur] && !s_reg.out) begin
          s_next.cur   = sel;
          s_next.phase = GFM_ENGAGE;
          s_next.out   = 1'b0;
        end else begin
          s_next.out = clk_in[s_reg.cur];
        end
      end
      GFM_ENGAGE: begin
        s_next.out = 1'b0;
        if (!clk_in[s_reg.cur]) begin
          s_next.phase = GFM_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{cur: '0, phase: GFM_RUN, out: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign clk_out = s_reg.out;
  assign cur_sel = s_reg.cur;

  property p_switch_low;
    @(posedge hclk) disable iff (!hresetn)
    $changed(s_reg.cur) |-> !s_reg.out && !$past(s_reg.out);
  endproperty
  a_switch_low: assert property (p_switch_low) else $error("source switched while high");
endmodule : cpc_gf_mux

// ==== cpc_clk_div.sv ====
// Programmable divider on a sampled clock level; divisor zero stops it.
// Assumes the input is synchronised to hclk.
`timescale 1ns/100ps
module cpc_clk_div #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Source and ratio
  input  wire logic         clk_in,
  input  wire logic [W-1:0] div,
  // Result
  output logic              clk_out
);
  import cpc_pkg::*;

  typedef struct packed {
    logic         prev;
    logic [W-1:0] cnt;
    logic         out;
  } cpc_div_state_t;

  cpc_div_state_t s_reg, s_next;

  // Toggle after div input edges: output period is div input periods
  always_comb begin
    s_next      = s_reg;
    s_next.prev = clk_in;
    if (div == '0) begin
      s_next.cnt = '0;
    end else if (clk_in != s_reg.prev) begin
      if (s_reg.cnt >= div - W'(1)) begin
        s_next.cnt = '0;
        s_next.out = ~s_reg.out;
      end else begin
        s_next.cnt = s_reg.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign clk_out = s_reg.out;

  property p_stop_holds;
    @(posedge hclk) disable iff (!hresetn)
    (div == '0) |=> (s_reg.out == $past(s_reg.out));
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped divider moved");
endmodule : cpc_clk_div

// ==== cpc_clock_ctrl.sv ====
// Clock source selection, system pll control, clock dividers, peripheral
// clock gating and sleep control, with an AHB-Lite register slave.
// Assumes oscillators arrive as levels from outside hclk and are resampled.
`timescale 1ns/100ps
module cpc_clock_ctrl
  import cpc_pkg::*;
#(
  parameter int unsigned NPERIPH = 8,
  parameter int unsigned NPDIV   = 3
) (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // Register bus
  input  wire cpc_pkg::cpc_ahb_req_t ahb_req,
  output cpc_pkg::cpc_ahb_rsp_t    ahb_rsp,
  // Oscillators and clock pins
  input  wire cpc_pkg::cpc_osc_t   osc,
  // Core sleep handshake
  input  wire logic                sleep_req,
  input  wire logic                wake_irq,
  output logic                     core_sleeping,
  // Generated clocks
  output logic                     cpu_clk,
  output logic [NPERIPH-1:0]       periph_clk,
  output logic [NPDIV-1:0]         periph_div_clk,
  output logic                     watchdog_clock,
  output logic                     clock_output_pin,
  // Analog pll macro
  output cpc_pkg::cpc_pll_ctl_t    pll_ctl
);
  import cpc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cpc_osc_t                  sync1;
    cpc_osc_t                  sync2;
    logic                      ap_valid;
    logic                      ap_write;
    logic [7:0]                ap_addr;
    logic [31:0]               hrdata;
    logic [1:0]                main_sel_reg;
    logic [1:0]                sys_src_reg;
    logic                      pll_in_reg;
    logic [8:0]                pll_ctrl_reg;
    logic [1:0]                out_sel_reg;
    logic                      wdt_sel_reg;
    logic [DIV_W-1:0]          cpu_div_reg;
    logic [NPERIPH-1:0]        pclk_en_reg;
    logic [NPDIV*DIV_W-1:0]    pdiv_reg;
    logic [PLL_CNT_W-1:0]      lock_cnt;
    logic                      lock;
    logic                      pll_clk;
    logic                      sleeping;
    logic                      cpu_run;
    logic                      cpu_clk;
    logic [NPERIPH-1:0]        pen_eff;
    logic [NPERIPH-1:0]        pclk;
    logic                      main_written;
  } cpc_ctrl_state_t;

  cpc_ctrl_state_t s_reg, s_next;

  logic       sys_clk;
  logic       pll_ref;
  logic       pll_post;
  logic       main_clk;
  logic [1:0] main_cur;
  logic       cpu_pre;
  logic       pll_en;
  logic [4:0] post_k;

  assign pll_en = s_reg.pll_ctrl_reg[PLL_EN_BIT];
  // Post ratio 2 << psel: smallest ratio two keeps duty at half
  assign post_k = POST_W'(POST_BASE << s_reg.pll_ctrl_reg[PLL_PSEL_LSB +: PLL_PSEL_W]);

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // Crystal oscillator or either external clock pin
  cpc_gf_mux #(.N(3), .W(2)) u_sys_mux (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_in  ({s_reg.sync2.crystal_input_pin,
               s_reg.sync2.external_clock_input_pin,
               s_reg.sync2.crystal_osc}),
    .sel     (s_reg.sys_src_reg),
    .clk_out (sys_clk),
    .cur_sel ()
  );

  // Pll reference: 12 MHz RC oscillator or the system source
  cpc_gf_mux #(.N(2), .W(1)) u_ref_mux (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_in  ({sys_clk, s_reg.sync2.internal_rc_osc}),
    .sel     (s_reg.pll_in_reg),
    .clk_out (pll_ref),
    .cur_sel ()
  );

  cpc_clk_div #(.W(POST_W)) u_post_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_in  (s_reg.sync2.current_controlled_osc),
    .div     (pll_en ? post_k : POST_W'(0)),
    .clk_out (pll_post)
  );

  // Direct RC, system source, pll, or low-frequency oscillator
  cpc_gf_mux #(.N(4), .W(2)) u_main_mux (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_in  ({s_reg.sync2.low_freq_osc, s_reg.pll_clk,
               sys_clk, s_reg.sync2.internal_rc_osc}),
    .sel     (s_reg.main_sel_reg),
    .clk_out (main_clk),
    .cur_sel (main_cur)
  );

  cpc_clk_div #(.W(DIV_W)) u_cpu_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_in  (main_clk),
    .div     (s_reg.cpu_div_reg),
    .clk_out (cpu_pre)
  );

  cpc_gf_mux #(.N(4), .W(2)) u_out_mux (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_in  ({main_clk, s_reg.sync2.low_freq_osc,
               s_reg.sync2.crystal_osc, s_reg.sync2.internal_rc_osc}),
    .sel     (s_reg.out_sel_reg),
    .clk_out (clock_output_pin),
    .cur_sel ()
  );

  // Watchdog oscillator reaches nothing but this mux
  cpc_gf_mux #(.N(2), .W(1)) u_wdt_mux (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_in  ({s_reg.sync2.watchdog_osc, s_reg.sync2.internal_rc_osc}),
    .sel     (s_reg.wdt_sel_reg),
    .clk_out (watchdog_clock),
    .cur_sel ()
  );

  genvar gi;
  generate
    for (gi = 0; gi < NPDIV; gi++) begin : g_pdiv
      cpc_clk_div #(.W(DIV_W)) u_pdiv (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clk_in  (main_clk),
        .div     (s_reg.pdiv_reg[gi*DIV_W +: DIV_W]),
        .clk_out (periph_div_clk[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Register read view
  // ----------------------------------------
  function automatic logic [31:0] rd_word(input cpc_ctrl_state_t st, input logic [7:0] a,
                                          input logic [1:0] cur);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      OFF_MAIN_SEL: w[1:0]         = st.main_sel_reg;
      OFF_SYS_SRC:  w[1:0]         = st.sys_src_reg;
      OFF_PLL_IN:   w[0]           = st.pll_in_reg;
      OFF_PLL_CTRL: w[8:0]         = st.pll_ctrl_reg;
      OFF_PLL_STAT: w[0]           = st.lock;
      OFF_OUT_SEL:  w[1:0]         = st.out_sel_reg;
      OFF_WDT_SEL:  w[0]           = st.wdt_sel_reg;
      OFF_CPU_DIV:  w[DIV_W-1:0]   = st.cpu_div_reg;
      OFF_PCLK_EN:  w[NPERIPH-1:0] = st.pclk_en_reg;
      OFF_STATUS: begin
        w[ST_SLEEP_BIT]       = st.sleeping;
        w[ST_MAIN_LSB +: 2]   = cur;
        w[ST_LOCK_BIT]        = st.lock;
      end
      default: begin
        for (int i = 0; i < NPDIV; i++) begin
          if (a == 8'(OFF_PDIV0 + OFF_PDIV_STEP * 8'(i))) begin
            w[DIV_W-1:0] = st.pdiv_reg[i*DIV_W +: DIV_W];
          end
        end
      end
    endcase
    return w;
  endfunction : rd_word

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = osc;
    s_next.sync2 = s_reg.sync1;

    // Address phase; read data registered so it stands in the data phase
    if (ahb_req.hready) begin
      s_next.ap_valid = ahb_req.hsel && ahb_req.htrans[1];
      s_next.ap_write = ahb_req.hwrite;
      s_next.ap_addr  = ahb_req.haddr[7:0];
      s_next.hrdata   = 32'h0000_0000;
      if (ahb_req.hsel && ahb_req.htrans[1] && !ahb_req.hwrite) begin
        s_next.hrdata = rd_word(s_reg, ahb_req.haddr[7:0], main_cur);
      end
    end

    // Data phase write; unmapped offsets are ignored
    if (s_reg.ap_valid && s_reg.ap_write) begin
      unique case (s_reg.ap_addr)
        OFF_MAIN_SEL: begin
          s_next.main_sel_reg = ahb_req.hwdata[1:0];
          s_next.main_written = 1'b1;
        end
        OFF_SYS_SRC:  s_next.sys_src_reg  = ahb_req.hwdata[1:0];
        OFF_PLL_IN:   s_next.pll_in_reg   = ahb_req.hwdata[0];
        OFF_PLL_CTRL: begin
          s_next.pll_ctrl_reg = ahb_req.hwdata[8:0];
          s_next.lock_cnt     = '0;
          s_next.lock         = 1'b0;
        end
        OFF_OUT_SEL:  s_next.out_sel_reg  = ahb_req.hwdata[1:0];
        OFF_WDT_SEL:  s_next.wdt_sel_reg  = ahb_req.hwdata[0];
        OFF_CPU_DIV:  s_next.cpu_div_reg  = ahb_req.hwdata[DIV_W-1:0];
        OFF_PCLK_EN:  s_next.pclk_en_reg  = ahb_req.hwdata[NPERIPH-1:0];
        default: begin
          for (int i = 0; i < NPDIV; i++) begin
            if (s_reg.ap_addr == 8'(OFF_PDIV0 + OFF_PDIV_STEP * 8'(i))) begin
              s_next.pdiv_reg[i*DIV_W +: DIV_W] = ahb_req.hwdata[DIV_W-1:0];
            end
          end
        end
      endcase
    end

    // Lock after the settling time; any write to the pll control register restarts it
    if (!pll_en) begin
      s_next.lock_cnt = '0;
      s_next.lock     = 1'b0;
    end else if (!(s_reg.ap_valid && s_reg.ap_write && s_reg.ap_addr == OFF_PLL_CTRL)) begin
      if (s_reg.lock_cnt != PLL_CNT_W'(PLL_SETTLE_CYC)) begin
        s_next.lock_cnt = s_reg.lock_cnt + PLL_CNT_W'(1);
      end
      s_next.lock = (s_reg.lock_cnt >= PLL_CNT_W'(PLL_SETTLE_CYC - 1));
    end

    // Bypassed pll passes its reference straight through
    s_next.pll_clk = pll_en ? pll_post : pll_ref;

    // Wake beats a sleep request arriving in the same cycle
    if (wake_irq) begin
      s_next.sleeping = 1'b0;
    end else if (sleep_req) begin
      s_next.sleeping = 1'b1;
    end

    // Gates move only while their clock is low, so no runt pulse
    if (!cpu_pre) begin
      s_next.cpu_run = !s_reg.sleeping;
    end
    s_next.cpu_clk = cpu_pre && s_reg.cpu_run;
    if (!main_clk) begin
      s_next.pen_eff = s_reg.pclk_en_reg;
    end
    // Sleep is not a term here: peripherals run on
    s_next.pclk = s_reg.pen_eff & {NPERIPH{main_clk}};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg              <= '0;
      s_reg.main_sel_reg <= RST_MAIN_SEL;
      s_reg.sys_src_reg  <= RST_SYS_SRC;
      s_reg.pll_ctrl_reg <= RST_PLL_CTRL;
      s_reg.cpu_div_reg  <= RST_CPU_DIV;
      s_reg.pdiv_reg     <= {NPDIV{RST_PDIV}};
      s_reg.cpu_run      <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ahb_rsp.hreadyout  = 1'b1;
  assign ahb_rsp.hresp      = 1'b0;
  assign ahb_rsp.hrdata     = s_reg.hrdata;
  assign core_sleeping      = s_reg.sleeping;
  assign cpu_clk            = s_reg.cpu_clk;
  assign periph_clk         = s_reg.pclk;
  assign pll_ctl.power_down = !pll_en;
  assign pll_ctl.mult       = 6'({1'b0, s_reg.pll_ctrl_reg[PLL_MSEL_LSB +: PLL_MSEL_W]}) + 6'h01;
  assign pll_ctl.ref_clk    = pll_ref;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_pll_start;
    $rose(pll_en);
  endsequence

  property p_rc_default;
    @(posedge hclk) disable iff (!hresetn)
    !s_reg.main_written |-> s_reg.main_sel_reg == SRC_RC && main_cur == SRC_RC;
  endproperty
  a_rc_default: assert property (p_rc_default) else $error("main clock left RC unbidden");

  property p_pll_off;
    @(posedge hclk) disable iff (!hresetn)
    !pll_en |-> pll_ctl.power_down && !s_reg.lock;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("pll active while disabled");

  property p_lock_wait;
    @(posedge hclk) disable iff (!hresetn)
    s_pll_start |-> !s_reg.lock [*8];
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("lock reported too early");

  property p_lock_time;
    @(posedge hclk) disable iff (!hresetn)
    $rose(s_reg.lock) |-> $past(s_reg.lock_cnt) == PLL_CNT_W'(PLL_SETTLE_CYC - 1);
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock not at settle count");

  property p_mult_range;
    @(posedge hclk) disable iff (!hresetn)
    pll_ctl.mult >= 6'h01 && pll_ctl.mult <= 6'h20;
  endproperty
  a_mult_range: assert property (p_mult_range) else $error("multiplier out of range");

  property p_post_ratio;
    @(posedge hclk) disable iff (!hresetn)
    $onehot(post_k) && !post_k[0];
  endproperty
  a_post_ratio: assert property (p_post_ratio) else $error("bad post divider ratio");

  property p_sleep_gate;
    @(posedge hclk) disable iff (!hresetn)
    s_reg.sleeping && !s_reg.cpu_run |=> !cpu_clk;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("core clock ran in sleep");

  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
    wake_irq |=> !core_sleeping ##1 1'b1;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not end sleep");

  property p_periph_run;
    @(posedge hclk) disable iff (!hresetn)
    1'b1 |=> periph_clk == ($past(s_reg.pen_eff) & {NPERIPH{$past(main_clk)}});
  endproperty
  a_periph_run: assert property (p_periph_run) else $error("peripheral clock wrong");
endmodule : cpc_clock_ctrl

// ==== cpc_clock_ctrl_tb_top.sv ====
// Self-checking bench for the clock and power control block.
// Assumes the block's zero-wait AHB-Lite slave and the hclk-sampled oscillators.
`timescale 1ns/100ps
module cpc_clock_ctrl_tb_top;
  import cpc_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic          hclk, hresetn, hsel, hwrite, sleep_req, wake_irq;
  logic [1:0]    htrans;
  logic [31:0]   haddr, hwdata, d;
  logic [7:0]    periph_clk;
  logic [7:0]    cnt = 8'h00;
  logic [2:0]    periph_div_clk;
  logic          cpu_clk, core_sleeping, watchdog_clock, clock_output_pin;
  logic [5:0]    v;
  cpc_ahb_req_t  req;
  cpc_ahb_rsp_t  rsp;
  cpc_osc_t      osc;
  cpc_pll_ctl_t  pll;
  int            n_mismatch, checks, n;
  int            ms [6] = '{0, 1, 1, 1, 3, 2};
  int            ss [6] = '{0, 0, 1, 2, 0, 0};
  int            me [6] = '{128, 64, 16, 8, 32, 128};
  int            oe [4] = '{128, 64, 32, 128};

  assign req = {hsel, haddr, htrans, hwrite, 3'h2, rsp.hreadyout, hwdata};
  // Distinct rates so each source but the current-controlled one, which runs at the RC rate, is recognisable by its toggle count
  assign osc = {cnt[2], cnt[3], cnt[5], cnt[6], cnt[4], cnt[7], cnt[2]};
  assign v   = {pll.ref_clk, periph_div_clk[0], clock_output_pin, periph_clk[0], watchdog_clock, cpu_clk};

  cpc_clock_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp), .osc(osc),
    .sleep_req(sleep_req), .wake_irq(wake_irq), .core_sleeping(core_sleeping), .cpu_clk(cpu_clk),
    .periph_clk(periph_clk), .periph_div_clk(periph_div_clk), .watchdog_clock(watchdog_clock),
    .clock_output_pin(clock_output_pin), .pll_ctl(pll));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) cnt <= cnt + 8'h01;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic rdy();
    @(posedge hclk);
    while (rsp.hreadyout !== 1'b1) @(posedge hclk);
  endtask : rdy
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= 1'b1; haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0; hwdata <= dat;
    rdy();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= 1'b0; haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    rdy();
    dat = rsp.hrdata;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Toggles of one clock output over 512 cycles, after the mux has settled
  task automatic near(input int idx, input int exp);
    logic p;
    n = 0;
    repeat (300) @(posedge hclk);
    p = v[idx];
    repeat (512) begin
      @(posedge hclk);
      if (v[idx] !== p) n++;
      p = v[idx];
    end
    checks++;
    if (n < exp - 3 || n > exp + 3) begin
      n_mismatch++;
      $display("BAD %0t clock %0d toggled %0d times, expected %0d", $time, idx, n, exp);
    end
  endtask : near

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(pll.power_down, 1'b1);
    chk(rsp.hresp, 1'b0);
    rd(OFF_MAIN_SEL, d); chk(d, 32'h0);
    rd(OFF_CPU_DIV, d); chk(d, 32'h1);
    rd(8'h3c, d); chk(d, 32'h0);
    near(1, 128);
    near(5, 128);
  endtask : t_reset
  task automatic t_main();
    for (int i = 0; i < 6; i++) begin
      wr(OFF_SYS_SRC, ss[i]);
      wr(OFF_MAIN_SEL, ms[i]);
      near(0, me[i]);
      rd(OFF_STATUS, d); chk(d[2:1], ms[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFF_OUT_SEL, i);
      near(3, oe[i]);
    end
    wr(OFF_WDT_SEL, 32'h1); near(1, 4);
    wr(OFF_CPU_DIV, 32'h2); near(0, 64);
    wr(OFF_PDIV0, 32'h4); near(4, 32);
  endtask : t_main
  task automatic t_pll();
    wr(OFF_PLL_CTRL, 32'h100);
    @(posedge hclk);
    chk({pll.power_down, pll.mult}, 7'h01);
    wr(OFF_PLL_CTRL, 32'h17f);
    @(posedge hclk);
    chk({pll.power_down, pll.mult}, 7'h20);
    repeat (1990) @(posedge hclk);
    rd(OFF_PLL_STAT, d); chk(d, 32'h0);
    repeat (10) @(posedge hclk);
    rd(OFF_PLL_STAT, d); chk(d, 32'h1);
    rd(OFF_STATUS, d); chk(d[3], 1'b1);
    wr(OFF_MAIN_SEL, 32'h2);
    near(0, 8);
    wr(OFF_MAIN_SEL, 32'h0);
    wr(OFF_PLL_CTRL, 32'h0);
    @(posedge hclk);
    rd(OFF_PLL_STAT, d); chk(d, 32'h0);
  endtask : t_pll
  task automatic t_sleep_gate();
    wr(OFF_PCLK_EN, 32'h0); near(2, 0);
    wr(OFF_PCLK_EN, 32'h1);
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(core_sleeping, 1'b1);
    near(0, 0);
    near(2, 128);
    wake_irq <= 1'b1;
    @(posedge hclk);
    wake_irq <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(core_sleeping, 1'b0);
    near(0, 64);
  endtask : t_sleep_gate
  // Reset in mid-run while asleep must wake the core and restore defaults
  task automatic t_reset_wake();
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk(core_sleeping, 1'b0);
    t_reset();
  endtask : t_reset_wake

  task automatic conclude();
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  initial begin
    {hresetn, hsel, hwrite, sleep_req, wake_irq, htrans, haddr, hwdata} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_pll();
    t_main();
    t_sleep_gate();
    t_reset_wake();
    conclude();
  end
  // Hang guard, well beyond the roughly 20k cycles the run needs
  initial begin
    repeat (60000) @(posedge hclk);
    n_mismatch++;
    conclude();
  end
endmodule : cpc_clock_ctrl_tb_top
